// >>> hdl/adcsq_irq.sv
// Sticky event status, enable mask and level interrupt of the sequencer.
`timescale 1ns/10ps
module adcsq_irq (
	// Clock and reset
	input  wire logic     clk_sys,
	input  wire logic     rst_n,
	// Core side
	adcsq_irq_if.unit     bus
);

	logic [adcsq_pkg::EVT_W-1:0] status_q;
	logic [adcsq_pkg::EVT_W-1:0] status_d;
	logic [adcsq_pkg::EVT_W-1:0] en_q;
	logic [adcsq_pkg::EVT_W-1:0] en_d;
	logic                        irq_q;

	// A new event wins over a clear in the same cycle.
	assign status_d = (status_q & ~bus.clr) | bus.evt;
	assign en_d     = bus.en_wr ? bus.en_wdata : en_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			status_q <= adcsq_pkg::RST_IRQ;
			en_q     <= adcsq_pkg::RST_IRQ;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			en_q     <= en_d;
			irq_q    <= |(status_d & en_d);
		end
	end

	assign bus.status = status_q;
	assign bus.en     = en_q;
	assign bus.irq    = irq_q;

endmodule

// >>> hdl/adcsq_top.sv
// Conversion chain sequencer with AHB-Lite registers and trigger handshake.
`timescale 1ns/10ps

// Behaviour
// - Injected chain aborts running normal channel, then reconverts it.
// - Channel abort in injected chain skips only that injected channel.
// - Completion flag set per finished channel; skipped ones stay clear.
// - End-of-chain interrupt event raised after every chain.
// - Chain abort ends scan chain; next scan restarts at the lowest enabled channel.
// - Trigger requests are served continuously while servicing is on.
// - Chain abort of injected chain sets its done flag, clears request.
// - Abort requests act on current channel or chain, then self-clear.
// - Every trigger conversion is acknowledged, even when aborted.
// - Analog clock stops in power-down or idle.
// - Clock select one equals digital clock; gating still applies.
module adcsq_top (
	// Clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           rst_n,
	// AHB-Lite slave
	input  wire logic                           hsel,
	input  wire logic [31:0]                    haddr,
	input  wire logic [1:0]                     htrans,
	input  wire logic                           hwrite,
	input  wire logic [2:0]                     hsize,
	input  wire logic [31:0]                    hwdata,
	input  wire logic                           hready,
	output logic      [31:0]                    hrdata,
	output logic                                hreadyout,
	output logic                                hresp,
	// Cross trigger unit
	input  wire logic                           trig_req,
	input  wire logic [adcsq_pkg::CH_W-1:0]     trig_chan,
	output logic                                trig_ack,
	// Analog converter
	output logic                                ana_start,
	output logic                                ana_abort,
	output logic      [adcsq_pkg::CH_W-1:0]     ana_chan,
	input  wire logic                           ana_eoc,
	input  wire logic [adcsq_pkg::RES_W-1:0]    ana_data,
	output logic                                ana_clk_en,
	output logic                                ana_clk_sel,
	// Interrupt
	output logic                                irq
);

	localparam int unsigned NC = adcsq_pkg::N_CH;
	localparam int unsigned CW = adcsq_pkg::CH_W;

	// ==========================================================
	// Declarations
	adcsq_pkg::adcsq_state_t state_q;
	adcsq_pkg::adcsq_state_t state_d;
	logic                    busy_q;
	logic                    busy_d;
	logic [CW-1:0]           n_ch_q;
	logic [CW-1:0]           n_ch_d;
	logic                    n_act_q;
	logic                    n_act_d;
	logic [CW-1:0]           j_ch_q;
	logic [CW-1:0]           j_ch_d;
	logic                    j_trig_q;
	logic                    j_trig_d;
	logic [CW-1:0]           cur_ch_q;
	logic                    start_q;
	logic                    scan_q;
	logic                    inj_q;
	logic                    chabt_q;
	logic                    chcan_q;
	logic                    tse_q;
	logic                    pwdn_q;
	logic                    csel_q;
	logic [NC-1:0]           nmask_q;
	logic [NC-1:0]           jmask_q;
	logic [NC-1:0]           done_q;
	logic [31:0]             result_q;
	logic [31:0]             hrdata_q;
	logic                    ap_wr_q;
	logic [7:0]              ap_addr_q;
	logic                    ana_start_q;
	logic                    ana_abort_q;
	logic                    trig_ack_q;
	logic                    clk_en_q;
	logic                    clk_sel_q;

	logic                    go_start;
	logic                    go_abort;
	logic                    ch_done;
	logic                    cend_evt;
	logic                    jdone_evt;
	logic                    ack;
	logic                    clr_inj;
	logic                    clr_chabt;
	logic                    clr_chcan;

	adcsq_irq_if irq_bus ();

	// ==========================================================
	// Lowest enabled channel at or above a start index
	function automatic logic [CW:0] pick(input logic [NC-1:0] m,
		input logic [CW:0] from);
		logic [CW:0] r;
		r = '0;
		for (int i = NC - 1; i >= 0; i--) begin
			if (m[i] && ((CW+1)'(i) >= from)) begin
				r = {1'b1, CW'(i)};
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Bus decode
	wire         ap_take  = hsel && htrans[1] && hready;
	wire         wr_ctrl  = ap_wr_q && (ap_addr_q == adcsq_pkg::OFS_CTRL);
	wire         wr_nmask = ap_wr_q && (ap_addr_q == adcsq_pkg::OFS_NMASK);
	wire         wr_jmask = ap_wr_q && (ap_addr_q == adcsq_pkg::OFS_JMASK);
	wire         wr_done  = ap_wr_q && (ap_addr_q == adcsq_pkg::OFS_DONE);
	wire         wr_iclr  = ap_wr_q && (ap_addr_q == adcsq_pkg::OFS_IRQ_CLR);
	wire         wr_ien   = ap_wr_q && (ap_addr_q == adcsq_pkg::OFS_IRQ_EN);
	wire [7:0]   ra       = haddr[7:0];
	wire [7:0]   ctrl_rd  = {csel_q, pwdn_q, tse_q, chcan_q, chabt_q,
		inj_q, scan_q, start_q};
	wire [31:0]  stat_rd  = (32'(n_act_q) << adcsq_pkg::S_NRUN)
		| (32'(state_q == adcsq_pkg::ST_INJ) << adcsq_pkg::S_INJ)
		| (32'(busy_q) << adcsq_pkg::S_BUSY)
		| (32'(state_q) << adcsq_pkg::S_STATE)
		| (32'(cur_ch_q) << adcsq_pkg::S_CH);
	wire [31:0]  rd_mux;

	// Unmapped and write-only offsets read as zero.
	assign rd_mux =
		(ra == adcsq_pkg::OFS_CTRL)   ? 32'(ctrl_rd) :
		(ra == adcsq_pkg::OFS_STATUS) ? stat_rd :
		(ra == adcsq_pkg::OFS_NMASK)  ? 32'(nmask_q) :
		(ra == adcsq_pkg::OFS_JMASK)  ? 32'(jmask_q) :
		(ra == adcsq_pkg::OFS_DONE)   ? 32'(done_q) :
		(ra == adcsq_pkg::OFS_IRQ_ST) ? 32'(irq_bus.status) :
		(ra == adcsq_pkg::OFS_IRQ_EN) ? 32'(irq_bus.en) :
		(ra == adcsq_pkg::OFS_RESULT) ? result_q : 32'h0000_0000;

	// ==========================================================
	// Channel selection
	wire [CW:0]  n_first  = pick(nmask_q, '0);
	wire [CW:0]  n_next   = pick(nmask_q, {1'b0, n_ch_q} + 1'b1);
	wire [CW:0]  j_first  = pick(jmask_q, '0);
	wire [CW:0]  j_next   = pick(jmask_q, {1'b0, j_ch_q} + 1'b1);
	wire         in_inj   = (state_q == adcsq_pkg::ST_INJ);
	wire         trig_take = tse_q && trig_req && !trig_ack_q;
	wire         sw_inj   = inj_q && j_first[CW] && !in_inj;
	wire [CW-1:0] go_ch   = in_inj ? j_ch_q : n_ch_q;

	// ==========================================================
	// Sequencer
	always_comb begin
		state_d   = state_q;
		busy_d    = busy_q;
		n_ch_d    = n_ch_q;
		n_act_d   = n_act_q;
		j_ch_d    = j_ch_q;
		j_trig_d  = j_trig_q;
		go_start  = 1'b0;
		go_abort  = 1'b0;
		ch_done   = 1'b0;
		cend_evt  = 1'b0;
		jdone_evt = 1'b0;
		ack       = 1'b0;
		clr_inj   = 1'b0;
		clr_chabt = 1'b0;
		clr_chcan = 1'b0;
		case (state_q)
			adcsq_pkg::ST_IDLE: begin
				// Abort requests with nothing running are dropped.
				clr_chabt = chabt_q;
				clr_chcan = chcan_q;
				if (trig_take) begin
					state_d  = adcsq_pkg::ST_INJ;
					j_trig_d = 1'b1;
					j_ch_d   = trig_chan;
				end else if (sw_inj) begin
					state_d  = adcsq_pkg::ST_INJ;
					j_trig_d = 1'b0;
					j_ch_d   = j_first[CW-1:0];
					clr_inj  = 1'b1;
				end else if (start_q && n_first[CW]) begin
					state_d  = adcsq_pkg::ST_NORM;
					n_ch_d   = n_first[CW-1:0];
					n_act_d  = 1'b1;
				end
			end
			adcsq_pkg::ST_NORM: begin
				if (chcan_q) begin
					go_abort  = busy_q;
					busy_d    = 1'b0;
					n_act_d   = 1'b0;
					cend_evt  = 1'b1;
					state_d   = adcsq_pkg::ST_IDLE;
				end else if (trig_take || sw_inj) begin
					// The normal channel index is kept for its restore.
					go_abort  = busy_q;
					busy_d    = 1'b0;
					state_d   = adcsq_pkg::ST_INJ;
					j_trig_d  = trig_take;
					j_ch_d    = trig_take ? trig_chan : j_first[CW-1:0];
					clr_inj   = !trig_take;
				end else if (!busy_q) begin
					go_start  = 1'b1;
					busy_d    = 1'b1;
				end else if (chabt_q || ana_eoc) begin
					go_abort  = chabt_q;
					ch_done   = !chabt_q;
					clr_chabt = chabt_q;
					busy_d    = 1'b0;
					if (n_next[CW]) begin
						n_ch_d = n_next[CW-1:0];
					end else begin
						cend_evt = 1'b1;
						if (scan_q && start_q && n_first[CW]) begin
							n_ch_d = n_first[CW-1:0];
						end else begin
							n_act_d = 1'b0;
							state_d = adcsq_pkg::ST_IDLE;
						end
					end
				end
			end
			adcsq_pkg::ST_INJ: begin
				if (chcan_q) begin
					go_abort  = busy_q;
					busy_d    = 1'b0;
					clr_chcan = 1'b1;
					jdone_evt = 1'b1;
					cend_evt  = 1'b1;
					ack       = j_trig_q;
					state_d   = n_act_q ? adcsq_pkg::ST_NORM
						: adcsq_pkg::ST_IDLE;
				end else if (!busy_q) begin
					go_start  = 1'b1;
					busy_d    = 1'b1;
				end else if (chabt_q || ana_eoc) begin
					go_abort  = chabt_q;
					ch_done   = !chabt_q;
					clr_chabt = chabt_q;
					ack       = j_trig_q;
					busy_d    = 1'b0;
					if (!j_trig_q && j_next[CW]) begin
						j_ch_d = j_next[CW-1:0];
					end else begin
						jdone_evt = 1'b1;
						cend_evt  = 1'b1;
						// Resume the preempted normal channel.
						state_d   = n_act_q ? adcsq_pkg::ST_NORM
							: adcsq_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				state_d = adcsq_pkg::ST_IDLE;
				busy_d  = 1'b0;
				n_act_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q  <= adcsq_pkg::ST_IDLE;
			busy_q   <= 1'b0;
			n_ch_q   <= '0;
			n_act_q  <= 1'b0;
			j_ch_q   <= '0;
			j_trig_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			busy_q   <= busy_d;
			n_ch_q   <= n_ch_d;
			n_act_q  <= n_act_d;
			j_ch_q   <= j_ch_d;
			j_trig_q <= j_trig_d;
		end
	end

	// ==========================================================
	// Analog and trigger strobes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ana_start_q <= 1'b0;
			ana_abort_q <= 1'b0;
			cur_ch_q    <= '0;
			trig_ack_q  <= 1'b0;
		end else begin
			ana_start_q <= go_start;
			ana_abort_q <= go_abort;
			trig_ack_q  <= ack;
			if (go_start) begin
				cur_ch_q <= go_ch;
			end
		end
	end

	// Clock gating holds in either clock select setting.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			clk_en_q  <= 1'b0;
			clk_sel_q <= 1'b0;
		end else begin
			clk_en_q  <= !pwdn_q && (state_d != adcsq_pkg::ST_IDLE);
			clk_sel_q <= csel_q;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			{csel_q, pwdn_q, tse_q, scan_q, start_q} <= 5'h00;
			inj_q   <= adcsq_pkg::RST_CTRL[adcsq_pkg::B_INJ];
			chabt_q <= adcsq_pkg::RST_CTRL[adcsq_pkg::B_CHABT];
			chcan_q <= adcsq_pkg::RST_CTRL[adcsq_pkg::B_CHCAN];
			nmask_q <= adcsq_pkg::RST_MASK;
			jmask_q <= adcsq_pkg::RST_MASK;
		end else begin
			if (wr_ctrl) begin
				start_q <= hwdata[adcsq_pkg::B_START];
				scan_q  <= hwdata[adcsq_pkg::B_SCAN];
				tse_q   <= hwdata[adcsq_pkg::B_TSE];
				pwdn_q  <= hwdata[adcsq_pkg::B_PWDN];
				csel_q  <= hwdata[adcsq_pkg::B_CLKSEL];
				inj_q   <= hwdata[adcsq_pkg::B_INJ];
				chabt_q <= hwdata[adcsq_pkg::B_CHABT];
				chcan_q <= hwdata[adcsq_pkg::B_CHCAN];
			end else begin
				inj_q   <= inj_q && !clr_inj;
				chabt_q <= chabt_q && !clr_chabt;
				chcan_q <= chcan_q && !clr_chcan;
			end
			if (wr_nmask) begin
				nmask_q <= hwdata[NC-1:0];
			end
			if (wr_jmask) begin
				jmask_q <= hwdata[NC-1:0];
			end
		end
	end

	// Per-channel done flags; completion wins over a write-one clear.
	for (genvar i = 0; i < NC; i++) begin : g_done
		wire set_i = ch_done && (cur_ch_q == CW'(i));
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				done_q[i] <= 1'b0;
			end else begin
				done_q[i] <= set_i || (done_q[i] && !(wr_done && hwdata[i]));
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			result_q <= 32'h0000_0000;
		end else if (ch_done) begin
			result_q <= (32'(cur_ch_q) << adcsq_pkg::R_CH) | 32'(ana_data);
		end
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
		end else begin
			ap_wr_q   <= ap_take && hwrite;
			ap_addr_q <= haddr[7:0];
			if (ap_take && !hwrite) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================================
	// Interrupt unit
	assign irq_bus.evt      = {ch_done, jdone_evt, cend_evt};
	assign irq_bus.clr      = wr_iclr ? hwdata[adcsq_pkg::EVT_W-1:0] : '0;
	assign irq_bus.en_wr    = wr_ien;
	assign irq_bus.en_wdata = hwdata[adcsq_pkg::EVT_W-1:0];

	adcsq_irq u_irq (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.bus     (irq_bus)
	);

	// ==========================================================
	// Outputs
	assign ana_start   = ana_start_q;
	assign ana_abort   = ana_abort_q;
	assign ana_chan    = cur_ch_q;
	assign trig_ack    = trig_ack_q;
	assign ana_clk_en  = clk_en_q;
	assign ana_clk_sel = clk_sel_q;
	assign irq         = irq_bus.irq;

endmodule

// >>> pkg/adcsq_irq_if.sv
// Event and register signals between the sequencer core and its interrupt unit.
`timescale 1ns/10ps
interface adcsq_irq_if;
	logic [adcsq_pkg::EVT_W-1:0] evt;
	logic [adcsq_pkg::EVT_W-1:0] clr;
	logic                        en_wr;
	logic [adcsq_pkg::EVT_W-1:0] en_wdata;
	logic [adcsq_pkg::EVT_W-1:0] status;
	logic [adcsq_pkg::EVT_W-1:0] en;
	logic                        irq;

	modport core (output evt, output clr, output en_wr, output en_wdata,
		input status, input en, input irq);
	modport unit (input evt, input clr, input en_wr, input en_wdata,
		output status, output en, output irq);
endinterface

// >>> pkg/adcsq_pkg.sv
// Shared constants and types of the conversion chain sequencer.
package adcsq_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned N_CH  = 8;
	localparam int unsigned CH_W  = 3;
	localparam int unsigned RES_W = 10;
	localparam int unsigned EVT_W = 3;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_NMASK   = 8'h08;
	localparam logic [7:0] OFS_JMASK   = 8'h0C;
	localparam logic [7:0] OFS_DONE    = 8'h10;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h1C;
	localparam logic [7:0] OFS_RESULT  = 8'h20;

	// ==========================================================
	// Control field positions
	localparam int unsigned B_START  = 0;
	localparam int unsigned B_SCAN   = 1;
	localparam int unsigned B_INJ    = 2;
	localparam int unsigned B_CHABT  = 3;
	localparam int unsigned B_CHCAN  = 4;
	localparam int unsigned B_TSE    = 5;
	localparam int unsigned B_PWDN   = 6;
	localparam int unsigned B_CLKSEL = 7;

	// ==========================================================
	// Status and result field positions
	localparam int unsigned S_NRUN   = 0;
	localparam int unsigned S_INJ    = 1;
	localparam int unsigned S_BUSY   = 2;
	localparam int unsigned S_STATE  = 4;
	localparam int unsigned S_CH     = 8;
	localparam int unsigned R_CH     = 16;

	// ==========================================================
	// Interrupt event positions
	localparam int unsigned E_CHAIN  = 0;
	localparam int unsigned E_JDONE  = 1;
	localparam int unsigned E_CONV   = 2;

	// ==========================================================
	// Reset values
	localparam logic [7:0]       RST_CTRL  = 8'h00;
	localparam logic [N_CH-1:0]  RST_MASK  = 8'h00;
	localparam logic [EVT_W-1:0] RST_IRQ   = 3'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_NORM = 2'b01,
		ST_INJ  = 2'b10
	} adcsq_state_t;

endpackage

// >>> testbench/adcsq_far.sv
// Behavioural analog converter and trigger requester for the sequencer.
`timescale 1ns/10ps
module adcsq_far (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// Test controls
	input  wire logic                        slow,
	input  wire logic                        trig_on,
	input  wire logic [adcsq_pkg::CH_W-1:0]  trig_sel,
	// Converter side
	input  wire logic                        ana_start,
	input  wire logic                        ana_abort,
	input  wire logic [adcsq_pkg::CH_W-1:0]  ana_chan,
	output logic                             ana_eoc = 1'b0,
	output logic      [adcsq_pkg::RES_W-1:0] ana_data,
	// Trigger side
	input  wire logic                        trig_ack,
	output logic                             trig_req = 1'b0,
	output logic      [adcsq_pkg::CH_W-1:0]  trig_chan = 3'h0
);
	logic [4:0]                  cnt_q = 5'h00;
	logic [adcsq_pkg::RES_W-1:0] pat_q = 10'h155;
	// ==========================================================
	// Converter
	// A dropped conversion never reports an end.
	always @(posedge clk_sys) begin
		pat_q <= pat_q + 10'h0B5;
		ana_eoc <= 1'b0;
		if (!rst_n || ana_abort) begin
			cnt_q <= 5'h00;
		end else if (ana_start) begin
			cnt_q <= slow ? 5'h14 : 5'h08;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
			ana_eoc <= cnt_q == 5'h01;
		end
	end
	assign ana_data = ana_eoc ? {ana_chan, 7'h2A} : pat_q;
	// ==========================================================
	// Trigger requester
	// Each request stands until its ack; a new one follows while enabled.
	always @(posedge clk_sys) begin
		if (!rst_n || trig_ack) begin
			trig_req <= 1'b0;
			trig_chan <= ~trig_chan;
		end else if (trig_on && !trig_req) begin
			trig_req <= 1'b1;
			trig_chan <= trig_sel;
		end
	end
endmodule

// >>> testbench/adcsq_sva.sv
// Port-level concurrent checks of the conversion chain sequencer.
`timescale 1ns/10ps
module adcsq_sva (
	// Clock and reset
	input wire logic                       clk_sys,
	input wire logic                       rst_n,
	// Register bus
	input wire logic                       hsel,
	input wire logic [31:0]                haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic                       hreadyout,
	// Trigger and converter
	input wire logic                       trig_ack,
	input wire logic                       ana_start,
	input wire logic                       ana_abort,
	input wire logic [adcsq_pkg::CH_W-1:0] ana_chan,
	input wire logic                       ana_eoc,
	input wire logic                       ana_clk_en,
	input wire logic                       ana_clk_sel
);
	// ==========================================================
	// Helpers
	logic busy_q;
	logic ctrl_wr;
	assign ctrl_wr = hsel && htrans[1] && hwrite && hreadyout
		&& haddr[7:0] == adcsq_pkg::OFS_CTRL;
	// A conversion is open from its start until its end or its abort.
	always_ff @(posedge clk_sys) begin
		if (!rst_n || ana_eoc || ana_abort) begin
			busy_q <= 1'b0;
		end else if (ana_start) begin
			busy_q <= 1'b1;
		end
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_start_clk_on: assert property (ana_start |-> ana_clk_en)
		else $error("conversion started with analog clock off");
	a_single_conv: assert property (ana_start |-> !busy_q)
		else $error("conversion started while another is open");
	a_start_pulse: assert property (ana_start |=> !ana_start)
		else $error("start pulse longer than one cycle");
	a_chan_held: assert property (!ana_start |-> $stable(ana_chan))
		else $error("channel changed without a start");
	a_ack_cause: assert property (trig_ack |->
		$past(ana_eoc) || $past(ana_abort) || ana_abort)
		else $error("trigger ack without end or abort");
	a_ack_pulse: assert property (trig_ack |=> !trig_ack)
		else $error("trigger ack longer than one cycle");
	a_abort_busy: assert property (ana_abort |-> busy_q)
		else $error("abort issued with no conversion open");
	a_sel_by_write: assert property ($changed(ana_clk_sel) |->
		$past(ctrl_wr, 2) || $past(ctrl_wr, 3))
		else $error("clock select changed without a write");
	a_clk_off_idle: assert property ($fell(ana_clk_en) |->
		!busy_q || ana_abort)
		else $error("analog clock stopped during a conversion");
	cover property (ana_abort);
	cover property (trig_ack);
	cover property ($fell(ana_clk_en));
endmodule

bind adcsq_top adcsq_sva adcsq_sva_i (.clk_sys, .rst_n, .hsel, .haddr,
	.htrans, .hwrite, .hreadyout, .trig_ack, .ana_start, .ana_abort,
	.ana_chan, .ana_eoc, .ana_clk_en, .ana_clk_sel);

// >>> testbench/tb.sv
// Self-checking bench of the conversion chain sequencer.
`timescale 1ns/10ps
module tb;
	// ==========================================================
	// Signals
	localparam logic [31:0] c_go   = 32'h1 << adcsq_pkg::B_START;
	localparam logic [31:0] c_scan = 32'h1 << adcsq_pkg::B_SCAN;
	localparam logic [31:0] c_inj  = 32'h1 << adcsq_pkg::B_INJ;
	localparam logic [31:0] c_chab = 32'h1 << adcsq_pkg::B_CHABT;
	localparam logic [31:0] c_can  = 32'h1 << adcsq_pkg::B_CHCAN;
	localparam logic [31:0] c_tse  = 32'h1 << adcsq_pkg::B_TSE;
	localparam logic [31:0] c_psel = 32'h3 << adcsq_pkg::B_PWDN;
	logic                        clk_sys = 1'b0;
	logic                        rst_n = 1'b0;
	logic                        hsel = 1'b1;
	logic [31:0]                 haddr = 32'h0;
	logic [1:0]                  htrans = 2'h0;
	logic                        hwrite = 1'b0;
	logic [31:0]                 hwdata = 32'h0;
	logic [31:0]                 hrdata;
	logic                        hready, hreadyout, hresp, irq;
	logic                        trig_req, trig_ack, ana_start, ana_abort;
	logic                        ana_eoc, ana_clk_en, ana_clk_sel;
	logic [adcsq_pkg::CH_W-1:0]  trig_chan, ana_chan, hi;
	logic [adcsq_pkg::RES_W-1:0] ana_data;
	logic                        slow = 1'b0, trig_on = 1'b0;
	logic                        rd_ph = 1'b0, trig_mode = 1'b0;
	logic [2:0]                  trig_sel = 3'h0;
	logic [31:0]                 rnd = 32'd59, rdat;
	logic [31:0]                 exp_q[$], msk_q[$];
	logic [2:0]                  ch_q[$];
	logic [7:0]                  rv_a[8] = '{adcsq_pkg::OFS_CTRL,
		adcsq_pkg::OFS_STATUS, adcsq_pkg::OFS_NMASK, adcsq_pkg::OFS_JMASK,
		adcsq_pkg::OFS_DONE, adcsq_pkg::OFS_IRQ_ST, adcsq_pkg::OFS_IRQ_EN,
		8'h40};
	int                          n_fail = 0, cmp_count = 0;

	always #25 clk_sys = ~clk_sys;
	assign hready = hreadyout;
	adcsq_top adcsq_top_i (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout,
		.hresp, .trig_req, .trig_chan, .trig_ack, .ana_start, .ana_abort,
		.ana_chan, .ana_eoc, .ana_data, .ana_clk_en, .ana_clk_sel, .irq);
	adcsq_far adcsq_far_i (.clk_sys, .rst_n, .slow, .trig_on, .trig_sel,
		.ana_start, .ana_abort, .ana_chan, .ana_eoc, .ana_data, .trig_ack,
		.trig_req, .trig_chan);

	// ==========================================================
	// Tasks
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] e);
		cmp_count++;
		if (seen !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic dph();
		@(posedge clk_sys);
		while (hready !== 1'b1) @(posedge clk_sys);
	endtask
	task automatic aph(logic [7:0] a, logic w);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		dph();
		htrans <= 2'h0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		aph(a, 1'b1);
		hwdata <= d;
		dph();
	endtask
	// A zero mask reads without a comparison.
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		aph(a, 1'b0);
		if (m != 0) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
			rd_ph <= 1'b1;
		end
		dph();
		rdat = hrdata;
		rd_ph <= 1'b0;
	endtask
	task automatic wait_idle();
		rdat = 32'h7;
		while (rdat[2:0] !== 3'h0) rd(adcsq_pkg::OFS_STATUS, 0, 0);
	endtask
	task automatic wait_ch(logic [2:0] c);
		do @(posedge clk_sys);
		while (ana_start !== 1'b1 || ana_chan !== c);
	endtask
	task automatic wait_ack();
		@(posedge clk_sys);
		for (int k = 1; k < 100 && trig_ack !== 1'b1; k++)
			@(posedge clk_sys);
		chk("trig_ack", trig_ack, 1);
	endtask
	task automatic push_mask(logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			if (m[i]) begin
				ch_q.push_back(i[2:0]);
				hi = i[2:0];
			end
		end
	endtask
	task automatic reset_chk();
		foreach (rv_a[i]) rd(rv_a[i], 0, 32'hFFFFFFFF);
		chk("irq", irq, 0);
		chk("ana_clk_sel", ana_clk_sel, 0);
	endtask

	// ==========================================================
	// Result monitor
	always @(posedge clk_sys) begin
		if (rd_ph && hready === 1'b1) begin
			chk("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
		end
		if (ana_start === 1'b1 && trig_mode) begin
			chk("trig chan", ana_chan, trig_sel);
		end else if (ana_start === 1'b1) begin
			chk("chan", ana_chan, ch_q.size() ? ch_q.pop_front() : 9);
		end
	end

	// ==========================================================
	// Sequence
	initial begin
		logic [7:0] m;
		tick(2);
		rst_n <= 1'b1;
		reset_chk();
		rnd = xs(rnd);
		m = rnd[7:0] | 8'h01;
		push_mask(m);
		wr(adcsq_pkg::OFS_IRQ_EN, 32'h1);
		wr(adcsq_pkg::OFS_NMASK, {24'h0, m});
		wr(adcsq_pkg::OFS_CTRL, c_go);
		wait_ch(0);
		wr(adcsq_pkg::OFS_CTRL, 0);
		chk("ana_clk_en", ana_clk_en, 1);
		wait_idle();
		rd(adcsq_pkg::OFS_DONE, m, 32'hFF);
		rd(adcsq_pkg::OFS_RESULT, {13'h0, hi, 6'h0, hi, 7'h2A}, 32'h703FF);
		rd(adcsq_pkg::OFS_IRQ_ST, 1, 1);
		chk("irq", irq, 1);
		chk("ana_clk_en", ana_clk_en, 0);
		wr(adcsq_pkg::OFS_IRQ_EN, 0);
		tick(2);
		chk("irq", irq, 0);
		wr(adcsq_pkg::OFS_IRQ_EN, 1);
		tick(2);
		chk("irq", irq, 1);
		wr(adcsq_pkg::OFS_IRQ_CLR, 7);
		tick(2);
		chk("irq", irq, 0);
		rd(adcsq_pkg::OFS_IRQ_ST, 0, 7);
		// Injected chain over a normal one, with and without a channel abort.
		for (int ab = 0; ab < 2; ab++) begin
			wr(adcsq_pkg::OFS_NMASK, 32'h1E);
			wr(adcsq_pkg::OFS_JMASK, 32'hE0);
			wr(adcsq_pkg::OFS_DONE, 32'hFF);
			ch_q = '{1, 2, 5, 6, 7, 2, 3, 4};
			slow <= ab[0];
			wr(adcsq_pkg::OFS_CTRL, c_go);
			wait_ch(1);
			wr(adcsq_pkg::OFS_CTRL, 0);
			wait_ch(2);
			wr(adcsq_pkg::OFS_CTRL, c_inj);
			if (ab == 1) begin
				wait_ch(7);
				wr(adcsq_pkg::OFS_CTRL, c_chab);
				tick(2);
				rd(adcsq_pkg::OFS_CTRL, 0, c_chab);
			end
			wait_idle();
			rd(adcsq_pkg::OFS_DONE, ab ? 32'h7E : 32'hFE, 32'hFF);
		end
		// Scan chain cancelled, then one clean scan.
		wr(adcsq_pkg::OFS_NMASK, 32'h0E);
		ch_q = '{1, 2, 1, 2, 3};
		wr(adcsq_pkg::OFS_CTRL, c_scan | c_go);
		wait_ch(2);
		wr(adcsq_pkg::OFS_CTRL, c_scan | c_can);
		wait_idle();
		rd(adcsq_pkg::OFS_CTRL, c_scan, 32'hFF);
		wr(adcsq_pkg::OFS_DONE, 32'hFF);
		wr(adcsq_pkg::OFS_CTRL, c_scan | c_go);
		wait_ch(3);
		wr(adcsq_pkg::OFS_NMASK, 0);
		wait_idle();
		rd(adcsq_pkg::OFS_DONE, 32'h0E, 32'hFF);
		chk("chain left", ch_q.size(), 0);
		// Trigger service, last request aborted with requests stopped.
		rnd = xs(rnd);
		trig_sel <= rnd[2:0];
		trig_mode <= 1'b1;
		wr(adcsq_pkg::OFS_CTRL, c_tse);
		wr(adcsq_pkg::OFS_NMASK, 32'h0E);
		trig_on <= 1'b1;
		repeat (3) wait_ack();
		wait_ch(trig_sel);
		trig_on <= 1'b0;
		wr(adcsq_pkg::OFS_CTRL, c_tse | c_chab);
		wait_ack();
		wait_idle();
		wr(adcsq_pkg::OFS_CTRL, 0);
		trig_mode <= 1'b0;
		// Clock select and power-down, then a reset while idle.
		wr(adcsq_pkg::OFS_CTRL, c_psel);
		tick(3);
		chk("ana_clk_sel", ana_clk_sel, 1);
		chk("ana_clk_en", ana_clk_en, 0);
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		reset_chk();
		print_verdict();
	end

	initial begin
		#1000000;
		n_fail++;
		print_verdict();
	end
endmodule
